// file: core/atd_pkg.sv
package atd_pkg;

    // Clock and timing, times in ns as printed, except the hold time in ms
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned PERIOD_TICK_NS     = 1200000;        // 1.2 ms
    localparam int unsigned COUNT_TICK_NS      = 3072000;        // 3.072 ms
    localparam int unsigned HOLD_TIME_MS       = 2360;           // 2.36 s
    localparam int unsigned DIGIT_RATE_HZ      = 10415;          // 10.415 kHz
    localparam int unsigned CLK_HZ             = 1000000000 / CLK_PERIOD_NS;

    // Derived cycle counts (every division rounds down)
    localparam int unsigned PERIOD_TICK_CYC    = PERIOD_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned COUNT_TICK_CYC     = COUNT_TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned HOLD_CYC           = (HOLD_TIME_MS * (CLK_HZ / 1000));
    localparam int unsigned DIGIT_TICK_CYC     = CLK_HZ / DIGIT_RATE_HZ;

    // Counter widths
    localparam int unsigned TMR_W              = 26;
    localparam int unsigned ADC_W              = 8;
    localparam int unsigned BCD_W              = 4;
    localparam int unsigned SEG_W              = 7;

    // Counting figures
    localparam logic [3:0]  UNITS_WRAP         = 4'h9;           // Last value before wrap at 10
    localparam logic [3:0]  TENS_MAX           = 4'h3;           // Tens never pass 3
    localparam logic [5:0]  OFFSET_TICKS       = 6'h32;          // 50 count ticks
    localparam logic [6:0]  SEG_BLANK_N        = 7'h7f;          // All segments dark

    // Digit enable positions
    localparam int unsigned DIG_UNITS          = 0;
    localparam int unsigned DIG_TENS           = 1;

    // Units counter phase after each period pulse
    typedef enum logic {
        ATD_OFFSET = 1'b0,
        ATD_COUNT  = 1'b1
    } atd_phase_t;

    // Display pins travel together
    typedef struct packed {
        logic [1:0]       digit_en;
        logic [SEG_W-1:0] seg_n;
    } atd_disp_t;

    // Latched decimal reading
    typedef struct packed {
        logic [BCD_W-1:0] tens;
        logic [BCD_W-1:0] units;
    } atd_bcd_t;

endpackage

// file: core/atd_seg_decode.sv
module atd_seg_decode
    import atd_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Digit in, segments out
    input  wire logic [BCD_W-1:0] digit,
    output logic      [SEG_W-1:0] seg_n
);

    logic [SEG_W-1:0] seg_d;
    logic [SEG_W-1:0] seg_q;

    // Bit order g..a; low lights a segment on common-anode digits
    always_comb begin
        unique case (digit)
            4'h0:    seg_d = 7'h40;
            4'h1:    seg_d = 7'h79;
            4'h2:    seg_d = 7'h24;
            4'h3:    seg_d = 7'h30;
            4'h4:    seg_d = 7'h19;
            4'h5:    seg_d = 7'h12;
            4'h6:    seg_d = 7'h02;
            4'h7:    seg_d = 7'h78;
            4'h8:    seg_d = 7'h00;
            4'h9:    seg_d = 7'h10;
            default: seg_d = SEG_BLANK_N; // Non-decimal codes stay dark
        endcase
    end

    // Registered so segments leave on a flop edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seg_q <= SEG_BLANK_N;
        end else begin
            seg_q <= seg_d;
        end
    end

    assign seg_n = seg_q;

endmodule

// file: core/atd_display.sv
// Overview of operation
// - Sensor channel selected by default; setpoint channel while hold timer is active.
// - Hold timer keeps output high 2.36 s after the button is released.
// - Period counter advances on a 1.2 ms tick.
// - Period counter pulses once on reaching the ADC value, then restarts at zero.
// - ADC value is unsigned, 0 to 255.
// - Period pulse restarts both decimal counters and forwards their digits.
// - Units counter wraps at 10; that wrap advances the tens counter until it reaches 3.
// - Tens counter advances only on the units wrap.
// - Latches capture both counters when the period counter pulses, before restart.
// - One shared decoder, fed units and tens alternately by a toggled select flop.
// - Displayed digit alternates at 10.415 kHz.
// - Digit enables and decoder data switch together; units with first digit.
// - Display covers 0 to 39 only.
// - Full ADC range maps onto readings 0 to 99 before offset.
// - Units counter held in reset 50 count ticks after each period pulse.
// - Displayed digit's anode enable high, the other low.
module atd_display
    import atd_pkg::*;
#(
    parameter int unsigned PERIOD_CYC = PERIOD_TICK_CYC,
    parameter int unsigned COUNT_CYC  = COUNT_TICK_CYC,
    parameter int unsigned HOLD_LEN   = HOLD_CYC
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // ADC reading and pushbutton pin
    input  wire logic [ADC_W-1:0] adc_data,
    input  wire logic             setpoint_button,
    // Amplifier channel select, high routes the setpoint channel
    output logic                  setpoint_select,
    // Shared segment lines and digit anode enables
    output atd_disp_t             disp
);

    // Divider step shared by all tick sources
    // Returns the wrap flag above the next count; the flag is the tick
    function automatic logic [TMR_W:0] tick_step(input logic [TMR_W-1:0] cnt, input int unsigned len);
        logic [TMR_W:0] res;
        res = '0;
        if (cnt >= TMR_W'(len - 1)) begin
            res = {1'b1, {TMR_W{1'b0}}};
        end else begin
            res = {1'b0, cnt + TMR_W'(1)};
        end
        return res;
    endfunction

    // Next decimal digit, back to zero after the last one
    function automatic logic [BCD_W-1:0] bcd_next(input logic [BCD_W-1:0] d, input logic [BCD_W-1:0] last);
        logic [BCD_W-1:0] res;
        res = d + 4'h1;
        if (d == last) begin
            res = '0;
        end
        return res;
    endfunction

    // ADC word synchroniser, three stages
    logic [ADC_W-1:0] adc_s1_q, adc_s2_q, adc_s3_q, adc_q, adc_d;

    // A new word counts once the second and third stages agree, so a word
    // caught with mixed old and new bits is never used
    always_comb begin
        adc_d = adc_q;
        if (adc_s2_q == adc_s3_q) begin
            adc_d = adc_s3_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            adc_s1_q <= '0;
            adc_s2_q <= '0;
            adc_s3_q <= '0;
            adc_q    <= '0;
        end else begin
            adc_s1_q <= adc_data;
            adc_s2_q <= adc_s1_q;
            adc_s3_q <= adc_s2_q;
            adc_q    <= adc_d;
        end
    end

    // Button synchroniser, three stages; also rejects one-sample bounce
    logic btn_s1_q, btn_s2_q, btn_s3_q, btn_q, btn_d;

    always_comb begin
        btn_d = btn_q;
        if (btn_s2_q == btn_s3_q) begin
            btn_d = btn_s3_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_s1_q <= 1'b0;
            btn_s2_q <= 1'b0;
            btn_s3_q <= 1'b0;
            btn_q    <= 1'b0;
        end else begin
            btn_s1_q <= setpoint_button;
            btn_s2_q <= btn_s1_q;
            btn_s3_q <= btn_s2_q;
            btn_q    <= btn_d;
        end
    end

    // Tick sources: one-cycle enables from dividers
    // Dividers free-run from reset and are not tied to the period pulse,
    // so the first interval after reset or a new reading may be short
    logic [TMR_W-1:0] per_div_q, per_div_d, cnt_div_q, cnt_div_d, dig_div_q, dig_div_d;
    logic             period_tick, count_tick, digit_tick;

    always_comb begin
        {period_tick, per_div_d} = tick_step(per_div_q, PERIOD_CYC);
        {count_tick, cnt_div_d}  = tick_step(cnt_div_q, COUNT_CYC);
        {digit_tick, dig_div_d}  = tick_step(dig_div_q, DIGIT_TICK_CYC);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            per_div_q <= '0;
            cnt_div_q <= '0;
            dig_div_q <= '0;
        end else begin
            per_div_q <= per_div_d;
            cnt_div_q <= cnt_div_d;
            dig_div_q <= dig_div_d;
        end
    end

    // Setpoint hold timer: stretches the button's falling edge
    // A press during the stretch clears the count, so the stretch starts over
    logic [TMR_W-1:0] hold_cnt_q, hold_cnt_d;
    logic             hold_q, hold_d;

    always_comb begin
        hold_cnt_d = hold_cnt_q;
        hold_d     = hold_q;
        if (btn_q) begin
            hold_d     = 1'b1;
            hold_cnt_d = '0;
        end else if (hold_q) begin
            if (hold_cnt_q >= TMR_W'(HOLD_LEN - 1)) begin
                hold_d     = 1'b0;
                hold_cnt_d = '0;
            end else begin
                hold_cnt_d = hold_cnt_q + TMR_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_cnt_q <= '0;
            hold_q     <= 1'b0;
        end else begin
            hold_cnt_q <= hold_cnt_d;
            hold_q     <= hold_d;
        end
    end

    // Select comes straight from the hold flop, so the amplifier sees no glitch
    assign setpoint_select = hold_q;

    // Period counter: turns the ADC value into a pulse interval
    // The count meets the reading live, so a reading that drops below the
    // count ends the interval at the next tick rather than wrapping
    logic [ADC_W-1:0] per_cnt_q, per_cnt_d;
    logic             period_pulse;

    always_comb begin
        per_cnt_d    = per_cnt_q;
        period_pulse = 1'b0;
        if (period_tick) begin
            // Unsigned compare; a zero reading pulses every tick
            if ({1'b0, per_cnt_q} + 9'h001 >= {1'b0, adc_q}) begin
                period_pulse = 1'b1;
                per_cnt_d    = '0;
            end else begin
                per_cnt_d = per_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            per_cnt_q <= '0;
        end else begin
            per_cnt_q <= per_cnt_d;
        end
    end

    // Decimal counters with offset hold and output latches
    // Latches hold the last complete interval, never a count in progress;
    // units keep wrapping once tens saturate, so an overflow shows 30 to 39
    atd_phase_t       phase_q, phase_d;
    logic [5:0]       off_cnt_q, off_cnt_d;
    logic [BCD_W-1:0] units_q, units_d, tens_q, tens_d;
    atd_bcd_t         latch_q, latch_d;

    always_comb begin
        phase_d   = phase_q;
        off_cnt_d = off_cnt_q;
        units_d   = units_q;
        tens_d    = tens_q;
        latch_d   = latch_q;
        if (period_pulse) begin
            // Capture before the restart takes effect
            latch_d   = '{tens: tens_q, units: units_q};
            units_d   = '0;
            tens_d    = '0;
            // A count tick on the pulse opens the new interval, so no tick
            // is lost when the two dividers line up
            if (count_tick) begin
                off_cnt_d = 6'h01;
            end else begin
                off_cnt_d = '0;
            end
            phase_d   = ATD_OFFSET;
        end else if (count_tick) begin
            unique case (phase_q)
                ATD_OFFSET: begin
                    // Skipping 50 ticks subtracts 50 from the reading
                    if (off_cnt_q == OFFSET_TICKS - 6'h01) begin
                        phase_d = ATD_COUNT;
                    end
                    off_cnt_d = off_cnt_q + 6'h01;
                end
                ATD_COUNT: begin
                    units_d = bcd_next(units_q, UNITS_WRAP);
                    if (units_q == UNITS_WRAP) begin
                        // Saturate rather than roll; only 0 to 39 is shown
                        if (tens_q != TENS_MAX) begin
                            tens_d = bcd_next(tens_q, TENS_MAX);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q   <= ATD_OFFSET;
            off_cnt_q <= '0;
            units_q   <= '0;
            tens_q    <= '0;
            latch_q   <= '0;
        end else begin
            phase_q   <= phase_d;
            off_cnt_q <= off_cnt_d;
            units_q   <= units_d;
            tens_q    <= tens_d;
            latch_q   <= latch_d;
        end
    end

    // Digit select flop and multiplexed decoder feed
    // Both enables come from one select bit, so they can never overlap;
    // they go dark together only in reset
    logic             sel_q, sel_d;
    logic [1:0]       en_q, en_d;
    logic [BCD_W-1:0] dec_in;
    logic [SEG_W-1:0] seg_n;

    always_comb begin
        sel_d = digit_tick ? ~sel_q : sel_q;
        // Enable and decoder both register from sel_q, so they move together
        dec_in = sel_q ? latch_q.tens : latch_q.units;
        en_d   = '0;
        en_d[sel_q ? DIG_TENS : DIG_UNITS] = 1'b1;
    end

    // Select and enables reset low, so the display is dark in reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_q <= 1'b0;
            en_q  <= '0;
        end else begin
            sel_q <= sel_d;
            en_q  <= en_d;
        end
    end

    // One decoder for both digits; its output flop lines up with en_q
    atd_seg_decode u_dec (
        .core_clk (core_clk),
        .rst      (rst),
        .digit    (dec_in),
        .seg_n    (seg_n)
    );

    // Both outputs leave straight from flops
    assign disp.digit_en = en_q;
    assign disp.seg_n    = seg_n;

endmodule

// file: dv/atd_display_sva.sv
module atd_display_sva
    import atd_pkg::*;
#(
    parameter int unsigned HOLD_LEN = 20
)
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Block inputs
    input  wire logic [ADC_W-1:0] adc_data,
    input  wire logic             setpoint_button,
    // Block outputs
    input  wire logic             setpoint_select,
    input  wire atd_disp_t        disp
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [11:0] dwell_q;
    logic [1:0]  prev_en_q;
    logic        seen_q;
    logic [7:0]  rel_q;
    logic        armed_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Slot length and release age; first slot skipped as it may be short
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dwell_q   <= 12'h0;
            prev_en_q <= 2'h0;
            seen_q    <= 1'b0;
            rel_q     <= 8'hff;
            armed_q   <= 1'b0;
        end else begin
            dwell_q   <= (disp.digit_en != prev_en_q) ? 12'h1 : dwell_q + 12'h1;
            prev_en_q <= disp.digit_en;
            seen_q    <= seen_q | ((disp.digit_en != prev_en_q) && (prev_en_q != 2'h0));
            rel_q     <= setpoint_button ? 8'h0 : ((rel_q == 8'hff) ? 8'hff : rel_q + 8'h1);
            armed_q   <= armed_q | (setpoint_button & setpoint_select);
        end
    end

    property p_onehot;
        (!$past(rst) && !$past(rst, 2)) |-> $onehot(disp.digit_en);
    endproperty
    a_onehot: assert property (p_onehot) else $error("digit enables not one-hot");

    property p_dwell;
        (disp.digit_en != prev_en_q && prev_en_q != 2'h0 && seen_q) |-> dwell_q == DIGIT_TICK_CYC;
    endproperty
    a_dwell: assert property (p_dwell) else $error("digit slot length wrong");

    property p_alt;
        ($past(disp.digit_en) != 2'h0 && $changed(disp.digit_en)) |-> disp.digit_en == ~$past(disp.digit_en);
    endproperty
    a_alt: assert property (p_alt) else $error("digits do not alternate");

    property p_seg;
        (disp.digit_en != 2'h0) |->
            disp.seg_n inside {7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78, 7'h00, 7'h10};
    endproperty
    a_seg: assert property (p_seg) else $error("segment pattern not a digit");

    property p_tens_cap;
        (disp.digit_en == 2'h2) |-> disp.seg_n inside {7'h40, 7'h79, 7'h24, 7'h30};
    endproperty
    a_tens_cap: assert property (p_tens_cap) else $error("tens digit above three");

    property p_sel_rise;
        setpoint_button [*8] |-> setpoint_select;
    endproperty
    a_sel_rise: assert property (p_sel_rise) else $error("setpoint channel not selected");

    property p_hold_high;
        (rel_q == HOLD_LEN && armed_q) |-> setpoint_select;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("select dropped before stretch end");

    property p_idle_low;
        (rel_q >= HOLD_LEN + 8) |-> !setpoint_select;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("select high with button idle");

    // Main scenarios reached
    c_tens: cover property (disp.digit_en == 2'h2 && disp.seg_n == 7'h24);
    c_rise: cover property ($rose(setpoint_select));
    c_fall: cover property ($fell(setpoint_select));
endmodule

bind atd_display atd_display_sva #(.HOLD_LEN(HOLD_LEN)) sva_u (
    .core_clk(core_clk), .rst(rst), .adc_data(adc_data), .setpoint_button(setpoint_button),
    .setpoint_select(setpoint_select), .disp(disp)
);

// file: dv/atd_far_model.sv
module atd_far_model
    import atd_pkg::*;
(
    // Clock and block outputs
    input  wire logic             core_clk,
    input  wire logic             setpoint_select,
    input  wire atd_disp_t        disp,
    // Channel voltages as ADC codes
    input  wire logic [ADC_W-1:0] sensor_code,
    input  wire logic [ADC_W-1:0] setpoint_code,
    // ADC result and digits read off the display
    output logic      [ADC_W-1:0] adc_data,
    output logic      [BCD_W-1:0] units_seen,
    output logic      [BCD_W-1:0] tens_seen
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lit pattern back to digit; f marks anything unreadable
    function automatic logic [3:0] seg_to_digit(input logic [6:0] s);
        case (s)
            7'h40: return 4'h0;
            7'h79: return 4'h1;
            7'h24: return 4'h2;
            7'h30: return 4'h3;
            7'h19: return 4'h4;
            7'h12: return 4'h5;
            7'h02: return 4'h6;
            7'h78: return 4'h7;
            7'h00: return 4'h8;
            7'h10: return 4'h9;
            default: return 4'hf;
        endcase
    endfunction

    // Amplifier mux then conversion, moved off the sampling edge
    always @(negedge core_clk) begin
        adc_data <= setpoint_select ? setpoint_code : sensor_code;
    end

    // Each digit read only while its own anode is high, once settled
    always @(negedge core_clk) begin
        if (disp.digit_en == 2'h1) begin
            units_seen <= seg_to_digit(disp.seg_n);
        end
        if (disp.digit_en == 2'h2) begin
            tens_seen <= seg_to_digit(disp.seg_n);
        end
    end
endmodule

// file: dv/atd_display_tb.sv
module atd_display_tb;
    import atd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned HOLD = 20;

    logic             core_clk;
    logic             rst;
    logic             setpoint_button;
    logic             setpoint_select;
    logic [ADC_W-1:0] adc_data;
    logic [ADC_W-1:0] sensor_code;
    logic [ADC_W-1:0] setpoint_code;
    logic [BCD_W-1:0] units_seen;
    logic [BCD_W-1:0] tens_seen;
    atd_disp_t        disp;
    int               n_errors;
    int               checks_done;

    // Short ticks: two count ticks per period tick, so reading = 2 * code - 50
    atd_display #(.PERIOD_CYC(4), .COUNT_CYC(2), .HOLD_LEN(HOLD)) dut_u (
        .core_clk(core_clk), .rst(rst), .adc_data(adc_data), .setpoint_button(setpoint_button),
        .setpoint_select(setpoint_select), .disp(disp)
    );

    atd_far_model far_u (
        .core_clk(core_clk), .setpoint_select(setpoint_select), .disp(disp), .sensor_code(sensor_code),
        .setpoint_code(setpoint_code), .adc_data(adc_data), .units_seen(units_seen), .tens_seen(tens_seen)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk_dig(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Two period pulses and a full slot of each digit fit in 7500 cycles
    task automatic t_reading(input logic [7:0] code, input logic [3:0] tens, input logic [3:0] units);
        sensor_code = code;
        cyc(7500);
        chk_dig("tens digit", tens, tens_seen);
        chk_dig("units digit", units, units_seen);
    endtask

    // Setpoint shown while pressed; stretch timed and restarted by a second press
    task automatic t_setpoint;
        setpoint_code = 8'h1e;
        sensor_code = 8'h25;
        cyc(7500);
        chk_bit("select idle", 1'b0, setpoint_select);
        setpoint_button = 1'b1;
        cyc(7500);
        chk_bit("select pressed", 1'b1, setpoint_select);
        chk_dig("setpoint tens", 4'h1, tens_seen);
        chk_dig("setpoint units", 4'h0, units_seen);
        setpoint_button = 1'b0;
        cyc(HOLD);
        chk_bit("select stretched", 1'b1, setpoint_select);
        setpoint_button = 1'b1;
        cyc(6);
        setpoint_button = 1'b0;
        cyc(HOLD);
        chk_bit("select restarted", 1'b1, setpoint_select);
        cyc(10);
        chk_bit("select released", 1'b0, setpoint_select);
        cyc(7500);
        chk_dig("sensor tens", 4'h2, tens_seen);
        chk_dig("sensor units", 4'h4, units_seen);
    endtask

    initial begin
        rst = 1'b1;
        setpoint_button = 1'b0;
        sensor_code = 8'h0;
        setpoint_code = 8'h0;
        n_errors = 0;
        checks_done = 0;
        cyc(3);
        rst = 1'b0;
        t_setpoint();
        t_reading(8'h1e, 4'h1, 4'h0);
        t_reading(8'h19, 4'h0, 4'h0);
        t_reading(8'h35, 4'h3, 4'h6);
        t_reading(8'hff, 4'h3, 4'h0);
        t_reading(8'h00, 4'h0, 4'h0);
        summarize();
    end

    // Run needs about 60060 cycles; cut a hang short beyond that
    initial begin
        cyc(80000);
        n_errors++;
        summarize();
    end
endmodule
